/* File: src/strc_map.vh */
`ifndef STRC_MAP_VH
`define STRC_MAP_VH
// How it works
// [RULE1] Cursor-key inputs stay off until enabled
// [RULE2] Keys reach program only on status display
// [RULE3] Program load or erase clears cursor enable
// [RULE4] Menu shows the option it changes to
// [RULE5] Settings locked while password protection active
// [RULE6] Power-up enters stored mode, default Run
// [RULE7] Displayless variant always starts in Run
// [RULE8] Run at power-up needs a valid program
// [RULE9] Startup mode survives erase and transfers
// [RULE10] Retention covers the whole fixed set
// [RULE11] Displayless with card erases retained values
// [RULE12] Retained data saved at every power-down
// [RULE13] Retention setting changes only in Stop
// [RULE14] Retention off: clear on stop, power-down
// [RULE15] Retention on: values kept across both
// [RULE16] Program transfer zeroes retained values
// [RULE17] Retention on-to-off clears retained values
// [RULE18] Program erase command clears retained values
// [RULE19] Transfer, disable, erase clearing only in Stop
// [RULE20] Retention setting travels with the program
// [RULE21] Upload leaves actual values unchanged
// [RULE22] Settings read before first program cycle

// Register byte offsets
`define STRC_SETTINGS   8'h00
`define STRC_MENU       8'h04
`define STRC_CMD        8'h08
`define STRC_STATUS     8'h0C
`define STRC_VIEW       8'h10
`define STRC_NVCNT      8'h14
`define STRC_VAL0       8'h20
`define STRC_VAL1       8'h24
`define STRC_VAL2       8'h28
// Settings and menu fields
`define STRC_F_CURSOR   0
`define STRC_F_START    1
`define STRC_F_RET      2
// Command fields
`define STRC_C_RUN      0
`define STRC_C_STOP     1
`define STRC_C_LOAD     2
`define STRC_C_ERASE    3
`define STRC_C_UPLOAD   4
`define STRC_C_HASPROG  8
`define STRC_C_LOADRET  9
// Reset values
`define STRC_RST_CURSOR 1'b0
`define STRC_RST_START  1'b1
`define STRC_RST_RET    1'b0
// Retained set and endurance
`define STRC_NVAL       3
`define STRC_VALW       16
`define STRC_ENDURANCE  17'h186A0
// Operating states
`define STRC_S_OFF      2'h0
`define STRC_S_LOAD     2'h1
`define STRC_S_STOP     2'h2
`define STRC_S_RUN      2'h3
// Bus responses
`define STRC_OKAY       2'h0
`define STRC_SLVERR     2'h2
`endif

/* File: src/strc_sync.v */
// Three-stage pin synchroniser; a change counts once stages two and three
// agree, so a single-cycle glitch through stage two is filtered out.
module strc_sync #(
    parameter W = 7
) (
    // Clock and reset
    input  wire         aclk,
    input  wire         aresetn,
    // Pins and synchronised levels
    input  wire [W-1:0] pin_in,
    output wire [W-1:0] lvl_out
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    reg [W-1:0] lvl_q;

    // Shift chain, all bits at once
    always @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= {W{1'b0}};
            s2_q <= {W{1'b0}};
            s3_q <= {W{1'b0}};
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Per-bit agreement filter
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            always @(posedge aclk) begin
                if (!aresetn) begin
                    lvl_q[g] <= 1'b0;
                end else if (s2_q[g] == s3_q[g]) begin
                    lvl_q[g] <= s3_q[g];
                end
            end
        end
    endgenerate

    assign lvl_out = lvl_q;
endmodule

/* File: src/strc_top.v */
`include "strc_map.vh"

// Startup, cursor-key and retention control with an AXI4-Lite slave.
module strc_top #(
    parameter NO_DISPLAY = 1'b0
) (
    // Clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // AXI4-Lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Device pins
    input  wire        power_good,
    input  wire        card_fitted,
    input  wire        pw_locked,
    input  wire [3:0]  cursor_keys,
    // Program side
    output reg         run_mode,
    output reg  [3:0]  prog_keys
);
    localparam NV = `STRC_NVAL;
    localparam VW = `STRC_VALW;

    // Synchronised pins
    wire [6:0] pins_s;
    wire       pg_s     = pins_s[0];
    wire       card_s   = pins_s[1];
    wire       locked_s = pins_s[2];
    wire [3:0] keys_s   = pins_s[6:3];

    strc_sync #(
        .W       (7)
    ) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin_in  ({cursor_keys, pw_locked, card_fitted, power_good}),
        .lvl_out (pins_s)
    );

    // Word index decode, shared by both channels; bit 4 flags a hit
    function [4:0] strc_dec;
        input [7:0] a;
        begin
            case (a)
                `STRC_SETTINGS: strc_dec = 5'h10;
                `STRC_MENU:     strc_dec = 5'h11;
                `STRC_CMD:      strc_dec = 5'h12;
                `STRC_STATUS:   strc_dec = 5'h13;
                `STRC_VIEW:     strc_dec = 5'h14;
                `STRC_NVCNT:    strc_dec = 5'h15;
                `STRC_VAL0:     strc_dec = 5'h18;
                `STRC_VAL1:     strc_dec = 5'h19;
                `STRC_VAL2:     strc_dec = 5'h1A;
                default:        strc_dec = 5'h00;
            endcase
        end
    endfunction

    // Control and retained state
    reg [1:0]    state_q;
    reg          cursor_q;
    reg          start_run_q;
    reg          ret_q;
    reg          prog_valid_q;
    reg          view_q;
    reg          upload_ret_q;
    reg          refused_q;
    reg          pg_prev_q;
    reg [16:0]   nvcnt_q;
    reg [VW-1:0] act_q [0:NV-1];
    reg [VW-1:0] nv_q  [0:NV-1];

    // Write channel holding registers
    reg [7:0]  awaddr_q;
    reg        aw_have_q;
    reg [31:0] wdata_q;
    reg [3:0]  wstrb_q;
    reg        w_have_q;

    wire       wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
    wire [4:0] wdec    = strc_dec(awaddr_q);
    wire       wr_ok   = wdec[4] & (wdec[3:0] != 4'h1)
                         & (wdec[3:0] != 4'h3) & (wdec[3:0] != 4'h5);
    wire       wr_go   = wr_fire & wr_ok & wstrb_q[0];
    wire       stopped = (state_q == `STRC_S_STOP);
    wire       pg_fall = pg_prev_q & ~pg_s;
    wire       pg_rise = ~pg_prev_q & pg_s;

    // Commands and settings writes
    wire [31:0] wd      = wdata_q;
    wire        is_set  = wr_go & (wdec[3:0] == 4'h0);
    wire        is_cmd  = wr_go & (wdec[3:0] == 4'h2);
    wire        c_run   = is_cmd & wd[`STRC_C_RUN];
    wire        c_stop  = is_cmd & wd[`STRC_C_STOP];
    wire        c_load  = is_cmd & wd[`STRC_C_LOAD];
    wire        c_erase = is_cmd & wd[`STRC_C_ERASE];
    wire        c_upl   = is_cmd & wd[`STRC_C_UPLOAD];
    wire        set_ok  = is_set & ~locked_s; // RULE5
    wire        ret_chg = set_ok & stopped
                          & (wd[`STRC_F_RET] != ret_q); // RULE13
    wire        ret_off = ret_chg & ret_q; // RULE17
    wire        xfer_ok = stopped & ~pg_fall; // RULE19
    wire        ld_ok   = c_load & xfer_ok;
    wire        er_ok   = c_erase & xfer_ok;
    wire        clr_cmd = ld_ok | er_ok | ret_off; // RULE16 RULE18

    // Index of a value register write, valid only in Run
    wire        val_wr  = wr_go & (wdec[3] == 1'b1)
                          & (state_q == `STRC_S_RUN);
    wire [1:0]  val_ix  = wdec[1:0];

    // Write address and data capture, in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h00000000;
            wstrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `STRC_OKAY;
        end else begin
            s_axi_awready <= ~aw_have_q & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready  <= ~w_have_q & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid & s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `STRC_OKAY : `STRC_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_have_q     <= 1'b0;
                w_have_q      <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Read data multiplexer
    wire [4:0]  rdec = strc_dec(s_axi_araddr);
    reg  [31:0] rd_d;
    always @* begin
        rd_d = 32'h00000000;
        case (rdec[3:0])
            4'h0: rd_d = {29'h0, ret_q, start_run_q, cursor_q};
            4'h1: rd_d = {29'h0, ~ret_q, ~start_run_q, ~cursor_q}; // RULE4
            4'h3: rd_d = {23'h0, view_q, refused_q, upload_ret_q,
                          nvcnt_q >= `STRC_ENDURANCE, locked_s,
                          prog_valid_q, 1'b0, state_q};
            4'h4: rd_d = {31'h0, view_q};
            4'h5: rd_d = {15'h0, nvcnt_q};
            4'h8: rd_d = {16'h0, act_q[0]};
            4'h9: rd_d = {16'h0, act_q[1]};
            4'hA: rd_d = {16'h0, act_q[2]};
            default: rd_d = 32'h00000000;
        endcase
    end

    // Read channel, one outstanding read
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `STRC_OKAY;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rdec[4] ? rd_d : 32'h00000000;
            s_axi_rresp   <= rdec[4] ? `STRC_OKAY : `STRC_SLVERR;
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // Settings, program presence and bookkeeping flags
    always @(posedge aclk) begin
        if (!aresetn) begin
            cursor_q     <= `STRC_RST_CURSOR; // RULE1
            start_run_q  <= `STRC_RST_START;
            ret_q        <= `STRC_RST_RET;
            prog_valid_q <= 1'b0;
            view_q       <= 1'b0;
            upload_ret_q <= 1'b0;
            refused_q    <= 1'b0;
        end else begin
            if (set_ok) begin
                cursor_q    <= wd[`STRC_F_CURSOR];
                start_run_q <= wd[`STRC_F_START];
            end
            if (ret_chg) begin
                ret_q <= wd[`STRC_F_RET];
            end
            if (wr_go & (wdec[3:0] == 4'h4)) begin
                view_q <= wd[0];
            end
            if (ld_ok) begin
                cursor_q <= 1'b0; // RULE3
                ret_q    <= wd[`STRC_C_LOADRET]; // RULE20
                if (wd[`STRC_C_HASPROG]) begin
                    prog_valid_q <= 1'b1;
                end
            end
            if (er_ok) begin
                cursor_q     <= 1'b0; // RULE3
                prog_valid_q <= 1'b0;
            end
            // Startup mode untouched by load and erase RULE9
            if (c_upl) begin
                upload_ret_q <= ret_q; // RULE20
            end
            if (is_set | is_cmd) begin
                refused_q <= (is_set & locked_s)
                             | ((c_load | c_erase) & ~xfer_ok)
                             | (is_set & ~stopped
                                & (wd[`STRC_F_RET] != ret_q));
            end
        end
    end

    // Operating state and power sequence
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q   <= `STRC_S_OFF;
            pg_prev_q <= 1'b0;
            run_mode  <= 1'b0;
        end else begin
            pg_prev_q <= pg_s;
            case (state_q)
                `STRC_S_OFF: begin
                    if (pg_rise) begin
                        state_q <= `STRC_S_LOAD; // RULE22
                    end
                end
                `STRC_S_LOAD: begin
                    if (prog_valid_q
                        & (start_run_q | NO_DISPLAY)) begin // RULE6 RULE7
                        state_q  <= `STRC_S_RUN;
                        run_mode <= 1'b1;
                    end else begin
                        state_q <= `STRC_S_STOP; // RULE8
                    end
                end
                `STRC_S_STOP: begin
                    if (c_run & prog_valid_q & ~pg_fall) begin
                        state_q  <= `STRC_S_RUN;
                        run_mode <= 1'b1;
                    end
                end
                `STRC_S_RUN: begin
                    if (c_stop | (er_ok)) begin
                        state_q  <= `STRC_S_STOP;
                        run_mode <= 1'b0;
                    end
                end
                default: state_q <= `STRC_S_OFF;
            endcase
            if (pg_fall & (state_q != `STRC_S_OFF)) begin
                state_q  <= `STRC_S_OFF;
                run_mode <= 1'b0;
            end
        end
    end

    // Actual values and their non-volatile copy, whole set at once RULE10
    integer i;
    always @(posedge aclk) begin
        if (!aresetn) begin
            nvcnt_q <= 17'h00000;
            for (i = 0; i < NV; i = i + 1) begin
                act_q[i] <= {VW{1'b0}};
                nv_q[i]  <= {VW{1'b0}};
            end
        end else if (pg_fall & (state_q != `STRC_S_OFF)) begin
            // Power-down save, kept or zeroed by the setting
            if (nvcnt_q != 17'h1FFFF) begin
                nvcnt_q <= nvcnt_q + 17'h00001; // RULE12
            end
            for (i = 0; i < NV; i = i + 1) begin
                nv_q[i]  <= ret_q ? act_q[i] : {VW{1'b0}}; // RULE15 RULE14
                act_q[i] <= {VW{1'b0}};
            end
        end else if (state_q == `STRC_S_LOAD) begin
            for (i = 0; i < NV; i = i + 1) begin
                if (ret_q & ~(NO_DISPLAY & card_s)) begin
                    act_q[i] <= nv_q[i]; // RULE15
                end else begin
                    act_q[i] <= {VW{1'b0}}; // RULE11
                    nv_q[i]  <= {VW{1'b0}};
                end
            end
        end else if (clr_cmd) begin
            for (i = 0; i < NV; i = i + 1) begin
                act_q[i] <= {VW{1'b0}}; // RULE16 RULE17 RULE18
                nv_q[i]  <= {VW{1'b0}};
            end
        end else if ((state_q == `STRC_S_RUN) & c_stop & ~ret_q) begin
            for (i = 0; i < NV; i = i + 1) begin
                act_q[i] <= {VW{1'b0}}; // RULE14
            end
        end else if (val_wr) begin
            act_q[val_ix] <= wd[VW-1:0];
        end
        // Upload touches no actual value RULE21
    end

    // Cursor keys gated to program inputs
    always @(posedge aclk) begin
        if (!aresetn) begin
            prog_keys <= 4'h0;
        end else begin
            prog_keys <= keys_s & {4{cursor_q & view_q
                         & (state_q == `STRC_S_RUN)}}; // RULE1 RULE2
        end
    end
endmodule

/* File: verification/strc_panel.sv */
// Supply, card slot, password switch and keypad beside the block
module strc_panel (
    // Clock
    input  wire        aclk,
    // Pins toward the block
    output logic       power_good,
    output logic       card_fitted,
    output logic       pw_locked,
    output logic [3:0] cursor_keys
);
    timeunit 1ns;
    timeprecision 1ns;

    // Supply off, no card, unlocked, no key at start
    initial begin
        {power_good, card_fitted, pw_locked, cursor_keys} = 7'h00;
    end

    // One operator or supply change, launched just after an edge
    task automatic setp(input logic pg, cd, lk, input logic [3:0] k);
        @(posedge aclk);
        power_good <= pg;
        card_fitted <= cd;
        pw_locked <= lk;
        cursor_keys <= k;
    endtask
endmodule

/* File: verification/strc_top_sva.sv */
// Port-level checks on the bus handshakes and the program side
module strc_chk (
    // Clock and reset
    input wire        aclk,
    input wire        aresetn,
    // Bus handshakes
    input wire        s_axi_awready,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    // Device side
    input wire        power_good,
    input wire        run_mode,
    input wire [3:0]  prog_keys
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Answers stand until taken
    a_b_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_r_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    // Read answer one cycle after the address
    a_r_latency: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    a_ar_return: assert property (s_axi_rvalid && s_axi_rready
        |=> !s_axi_rvalid && s_axi_arready)
        else $error("read channel not reopened");
    // Response only after both channels are closed
    a_b_closes: assert property ($rose(s_axi_bvalid)
        |-> !s_axi_awready && !s_axi_wready)
        else $error("response with channel open");
    a_b_return: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid ##1 (s_axi_awready && s_axi_wready))
        else $error("write channels not reopened");
    // Keys reach the program only in Run
    a_keys_run: assert property (
        !run_mode [*3] |-> prog_keys == 4'h0)
        else $error("keys passed outside Run");
    // Loss of supply leaves Run
    a_power_off: assert property (
        !power_good [*8] |-> !run_mode)
        else $error("Run without supply");

    // Main scenarios
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_run: cover property ($rose(run_mode));
    c_keys: cover property (prog_keys != 4'h0);
endmodule

bind strc_top strc_chk u_chk (
    .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .power_good,
    .run_mode, .prog_keys
);

/* File: verification/strc_top_bench.sv */
`include "strc_map.vh"

module strc_top_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, run_mode, run_nd;
    logic        power_good, card_fitted, pw_locked;
    logic [3:0]  keys, prog_keys;
    int          err_total = 0;
    int          n_tests = 0;

    // 20 MHz clock
    always #25 aclk = ~aclk;

    strc_top dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .power_good(power_good),
        .card_fitted(card_fitted), .pw_locked(pw_locked),
        .cursor_keys(keys), .run_mode(run_mode), .prog_keys(prog_keys)
    );

    strc_panel panel (.aclk(aclk), .power_good(power_good),
        .card_fitted(card_fitted), .pw_locked(pw_locked),
        .cursor_keys(keys));

    // Displayless variant
    strc_top #(.NO_DISPLAY(1'b1)) dut_nd (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(),
        .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(),
        .s_axi_rvalid(), .s_axi_rready(rready),
        .power_good(power_good), .card_fitted(card_fitted),
        .pw_locked(pw_locked), .cursor_keys(keys),
        .run_mode(run_nd), .prog_keys()
    );

    // Verdict and end of run
    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // Bus write, both channels offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int i;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        i = 0;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid === 1'b1 && !bready) bready <= 1'b1;
            i++;
        end while ((bvalid & bready) !== 1'b1 && i < 60);
        bready <= 1'b0;
        chk("bresp", {30'h0, bresp}, {30'h0, er});
        err_total += int'(i >= 60);
        if (i >= 60) conclude();
    endtask

    // Bus read
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        i = 0;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid === 1'b1 && !rready) rready <= 1'b1;
            i++;
        end while ((rvalid & rready) !== 1'b1 && i < 60);
        rready <= 1'b0;
        d = rdata;
        err_total += int'(i >= 60);
        if (i >= 60) conclude();
    endtask

    // Read and compare under a mask
    task automatic rc(input string nm, input logic [7:0] a,
                      input logic [31:0] m, e);
        logic [31:0] v;
        rd(a, v);
        chk(nm, v & m, e);
        chk("rresp", {30'h0, rresp}, {30'h0, `STRC_OKAY});
    endtask

    // Poll the operating state a bounded number of times
    task automatic ws(input logic [1:0] e);
        logic [31:0] v;
        for (int i = 0; i < 20; i++) begin
            rd(`STRC_STATUS, v);
            if (v[1:0] === e) break;
        end
        chk("state", {30'h0, v[1:0]}, {30'h0, e});
    endtask

    // Run or stop command
    task automatic go(input logic r);
        wr(`STRC_CMD, r ? 32'h1 : 32'h2, `STRC_OKAY);
        ws(r ? `STRC_S_RUN : `STRC_S_STOP);
    endtask

    // Factory state and refused places
    task automatic t_defaults;
        rc("settings", `STRC_SETTINGS, 32'h7, 32'h2);
        rc("menu", `STRC_MENU, 32'h7, 32'h5);
        rc("nvcnt", `STRC_NVCNT, 32'hFFFFFFFF, 32'h0);
        wr(`STRC_MENU, 32'h0, `STRC_SLVERR);
        wr(8'hFC, 32'h0, `STRC_SLVERR);
        panel.setp(1'b1, 1'b1, 1'b0, 4'hA);
        ws(`STRC_S_STOP);
    endtask

    // Load clears the key enable; keys pass only on status display
    task automatic t_keys;
        wr(`STRC_SETTINGS, 32'h3, `STRC_OKAY);
        wr(`STRC_CMD, 32'h104, `STRC_OKAY);
        rc("cursor", `STRC_SETTINGS, 32'h7, 32'h2);
        wr(`STRC_VIEW, 32'h1, `STRC_OKAY);
        go(1'b1);
        repeat (8) @(posedge aclk);
        chk("keys", {28'h0, prog_keys}, 32'h0);
        wr(`STRC_SETTINGS, 32'h3, `STRC_OKAY);
        rc("menu", `STRC_MENU, 32'h7, 32'h4);
        repeat (8) @(posedge aclk);
        chk("keys", {28'h0, prog_keys}, 32'hA);
        wr(`STRC_VIEW, 32'h0, `STRC_OKAY);
        repeat (8) @(posedge aclk);
        chk("keys", {28'h0, prog_keys}, 32'h0);
    endtask

    // Retention off across stop; on across stop, power cycle and upload
    task automatic t_retain;
        wr(`STRC_SETTINGS, 32'h6, `STRC_OKAY);
        rc("ret", `STRC_SETTINGS, 32'h4, 32'h0);
        rc("refused", `STRC_STATUS, 32'h80, 32'h80);
        wr(`STRC_VAL0, 32'h1234, `STRC_OKAY);
        go(1'b0);
        rc("val", `STRC_VAL0, 32'hFFFF, 32'h0);
        wr(`STRC_SETTINGS, 32'h6, `STRC_OKAY);
        rc("ret", `STRC_SETTINGS, 32'h4, 32'h4);
        go(1'b1);
        for (int k = 0; k < 3; k++)
            wr(`STRC_VAL0 + 8'(4 * k), 32'h1110 + 32'(k), `STRC_OKAY);
        go(1'b0);
        panel.setp(1'b0, 1'b0, 1'b0, 4'h0);
        ws(`STRC_S_OFF);
        rc("nvcnt", `STRC_NVCNT, 32'hFFFFFFFF, 32'h1);
        panel.setp(1'b1, 1'b0, 1'b0, 4'h0);
        ws(`STRC_S_RUN);
        wr(`STRC_CMD, 32'h10, `STRC_OKAY);
        rc("copied", `STRC_STATUS, 32'h40, 32'h40);
        for (int k = 0; k < 3; k++)
            rc("val", `STRC_VAL0 + 8'(4 * k), 32'hFFFF,
               32'h1110 + 32'(k));
        go(1'b0);
        wr(`STRC_SETTINGS, 32'h2, `STRC_OKAY);
        for (int k = 0; k < 3; k++)
            rc("val", `STRC_VAL0 + 8'(4 * k), 32'hFFFF, 32'h0);
    endtask

    // Load from a card without a program
    task automatic t_transfer;
        wr(`STRC_SETTINGS, 32'h6, `STRC_OKAY);
        go(1'b1);
        wr(`STRC_VAL1, 32'h00AB, `STRC_OKAY);
        go(1'b0);
        rc("val", `STRC_VAL1, 32'hFFFF, 32'hAB);
        wr(`STRC_CMD, 32'h4, `STRC_OKAY);
        rc("val", `STRC_VAL1, 32'hFFFF, 32'h0);
        rc("prog", `STRC_STATUS, 32'h8, 32'h8);
    endtask

    // Password lock, then startup in Stop
    task automatic t_lock;
        panel.setp(1'b1, 1'b0, 1'b1, 4'h0);
        repeat (8) @(posedge aclk);
        wr(`STRC_SETTINGS, 32'h0, `STRC_OKAY);
        rc("lock", `STRC_SETTINGS, 32'h7, 32'h2);
        rc("locked", `STRC_STATUS, 32'h10, 32'h10);
        panel.setp(1'b1, 1'b0, 1'b0, 4'h0);
        repeat (8) @(posedge aclk);
        wr(`STRC_SETTINGS, 32'h0, `STRC_OKAY);
        panel.setp(1'b0, 1'b0, 1'b0, 4'h0);
        ws(`STRC_S_OFF);
        panel.setp(1'b1, 1'b0, 1'b0, 4'h0);
        ws(`STRC_S_STOP);
        chk("nd run", {31'h0, run_nd}, 32'h1);
        wr(`STRC_SETTINGS, 32'h2, `STRC_OKAY);
    endtask

    // Erase refused in Run, clears values in Stop
    task automatic t_erase;
        wr(`STRC_SETTINGS, 32'h6, `STRC_OKAY);
        go(1'b1);
        wr(`STRC_VAL2, 32'h0077, `STRC_OKAY);
        wr(`STRC_CMD, 32'h8, `STRC_OKAY);
        rc("prog", `STRC_STATUS, 32'h8, 32'h8);
        go(1'b0);
        rc("val", `STRC_VAL2, 32'hFFFF, 32'h77);
        wr(`STRC_CMD, 32'h8, `STRC_OKAY);
        rc("val", `STRC_VAL2, 32'hFFFF, 32'h0);
        rc("prog", `STRC_STATUS, 32'h8, 32'h0);
        rc("start", `STRC_SETTINGS, 32'h2, 32'h2);
    endtask

    // Reset, then the scenarios in order
    initial begin
        aclk = 1'b0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = 48'h0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_defaults();
        t_keys();
        t_retain();
        t_transfer();
        t_lock();
        t_erase();
        conclude();
    end
endmodule
